//--- shared/asp_pkg.sv
package asp_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] SCAN_SELECT_HIGH_OFS = 8'h00;
    localparam logic [7:0] SCAN_SELECT_LOW_OFS = 8'h04;
    localparam logic [7:0] PIN_ANALOG_CONFIG_HIGH_OFS = 8'h08;
    localparam logic [7:0] PIN_ANALOG_CONFIG_LOW_OFS = 8'h0c;
    localparam logic [7:0] SECOND_PIN_CONFIG_LOW_OFS = 8'h10;
    localparam logic [7:0] CONTROL_OFS = 8'h14;
    localparam logic [7:0] SCAN_STATUS_OFS = 8'h18;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam int CTRL_DISABLE_BIT = 0;
    localparam int CTRL_SECOND_DISABLE_BIT = 1;
    localparam int CTRL_SCAN_RUN_BIT = 2;
    localparam int STAT_INDEX_LSB = 0;
    localparam int STAT_SLOT_BIT = 8;
    localparam int STAT_RUN_BIT = 9;

    // Number of analog inputs implemented on the part (plain default).
    localparam logic [5:0] INPUTS_PRESENT = 6'h20;
    // Scan step interval in clock cycles (one enable pulse per step).
    localparam logic [7:0] SCAN_STEP_CYCLES = 8'h10;

    // AXI4-Lite responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Converter mux source for one scan slot.
    typedef enum logic [2:0]
    {
        ASP_SRC_PIN = 3'b001,
        ASP_SRC_LOW_REFERENCE_LEVEL = 3'b010,
        ASP_SRC_NEGREF = 3'b100
    } asp_src_t;

    // One scan slot handed to the converter.
    typedef struct packed
    {
        logic valid;
        logic [4:0] index;
        asp_src_t source;
    } asp_slot_t;

endpackage

//--- src/asp_scan_pick.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Next selected input search
// --------------------------------------------------------------------
// Finds the lowest set mask bit strictly above the current index, or
// wraps to the lowest set bit overall.
module asp_scan_pick
(
    // Scan mask and current position.
    input wire logic [31:0] i_mask,
    input wire logic [4:0] i_cur,
    // Result.
    output logic o_found,
    output logic [4:0] o_next
);

    // Searches from high to low so the last hit is the lowest one.
    always_comb
    begin
        o_found = 1'b0;
        o_next = 5'h00;
        for (int k = 31; k >= 0; k--)
        begin
            if (i_mask[k])
            begin
                o_found = 1'b1;
                o_next = 5'(k);
            end
        end
        for (int k = 31; k >= 0; k--)
        begin
            if (i_mask[k] && (5'(k) > i_cur))
            begin
                o_next = 5'(k);
            end
        end
    end

endmodule // asp_scan_pick

//--- src/asp_scan_cfg.sv
`timescale 1ns/1ps

// Behaviour
// - 32-bit scan mask in two 16-bit registers.
// - Mask bit n selects analog input n.
// - High mask bits always writable.
// - Missing high input converts low reference level.
// - Missing low input converts negative reference.
// - Set pin bit: digital, read on, ground.
// - Clear pin bit: analog, read off, sampled.
// - Pin bit n maps to analog input n.
// - Pin bits writable, ignored if input missing.
// - Module disabled forces all pins digital.
// - Second converter covers only inputs 0-15.
// - Both low pin registers affect inputs 0-15.
module asp_scan_cfg
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response.
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read.
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Pin mode outputs, one bit per analog input.
    output logic [31:0] o_pin_digital,
    output logic [31:0] o_port_read_en,
    output logic [31:0] o_mux_to_ground,
    // Scan slot offered to the converter.
    output asp_pkg::asp_slot_t o_slot
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] scan_select_high_reg; // Mask for inputs 16 to 31.
    logic [15:0] scan_select_low_reg; // Mask for inputs 0 to 15.
    logic [15:0] pin_analog_config_high_reg; // Pin bits 16 to 31.
    logic [15:0] pin_analog_config_low_reg; // First converter bits 0 to 15.
    logic [15:0] second_pin_config_low_reg; // Second converter bits 0 to 15.
    logic [2:0] control_reg; // Disable bits and scan run.
    logic [31:0] scan_mask; // Whole mask, bit n is input n.
    logic [31:0] present; // Inputs that exist on the part.

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic aw_held_reg; // Write address captured.
    logic w_held_reg; // Write data captured.
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write; // Both halves present and no response pending.

    assign do_write = aw_held_reg && w_held_reg && !o_bvalid;

    // Address and data are taken in either order and held until used.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (o_awready && i_awvalid)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end
            else if (do_write)
            begin
                aw_held_reg <= 1'b0;
            end
            if (o_wready && i_wvalid)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            else if (do_write)
            begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Ready is high while the holding slot is free.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end
        else
        begin
            o_awready <= !(aw_held_reg || (o_awready && i_awvalid)) || do_write;
            o_wready <= !(w_held_reg || (o_wready && i_wvalid)) || do_write;
        end
    end

    // Response issued one cycle after both halves are held.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_bvalid <= 1'b0;
            o_bresp <= asp_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            o_bvalid <= 1'b1;
            // Unmapped addresses and the status word answer with an error.
            case (awaddr_reg)
                asp_pkg::SCAN_SELECT_HIGH_OFS, asp_pkg::SCAN_SELECT_LOW_OFS,
                asp_pkg::PIN_ANALOG_CONFIG_HIGH_OFS, asp_pkg::PIN_ANALOG_CONFIG_LOW_OFS,
                asp_pkg::SECOND_PIN_CONFIG_LOW_OFS, asp_pkg::CONTROL_OFS:
                    o_bresp <= asp_pkg::RESP_OKAY;
                default:
                    o_bresp <= asp_pkg::RESP_SLVERR;
            endcase
        end
        else if (i_bready)
        begin
            o_bvalid <= 1'b0;
        end
    end

    // Byte-lane merge of a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0])
        begin
            r[7:0] = d[7:0];
        end
        if (s[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // Every implemented bit is writable whether or not its input exists.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            scan_select_high_reg <= asp_pkg::REG16_RESET;
            scan_select_low_reg <= asp_pkg::REG16_RESET;
            pin_analog_config_high_reg <= asp_pkg::REG16_RESET;
            pin_analog_config_low_reg <= asp_pkg::REG16_RESET;
            second_pin_config_low_reg <= asp_pkg::REG16_RESET;
            control_reg <= asp_pkg::CONTROL_RESET;
        end
        else if (do_write)
        begin
            unique case (awaddr_reg)
                asp_pkg::SCAN_SELECT_HIGH_OFS:
                    scan_select_high_reg <= merge16(scan_select_high_reg, wdata_reg,
                                                    wstrb_reg);
                asp_pkg::SCAN_SELECT_LOW_OFS:
                    scan_select_low_reg <= merge16(scan_select_low_reg, wdata_reg,
                                                   wstrb_reg);
                asp_pkg::PIN_ANALOG_CONFIG_HIGH_OFS:
                    pin_analog_config_high_reg <= merge16(pin_analog_config_high_reg,
                                                          wdata_reg, wstrb_reg);
                asp_pkg::PIN_ANALOG_CONFIG_LOW_OFS:
                    pin_analog_config_low_reg <= merge16(pin_analog_config_low_reg,
                                                         wdata_reg, wstrb_reg);
                asp_pkg::SECOND_PIN_CONFIG_LOW_OFS:
                    second_pin_config_low_reg <= merge16(second_pin_config_low_reg,
                                                         wdata_reg, wstrb_reg);
                asp_pkg::CONTROL_OFS:
                    if (wstrb_reg[0])
                    begin
                        control_reg <= wdata_reg[2:0];
                    end
                default:
                    control_reg <= control_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    logic [7:0] scan_status; // Current slot state as seen by software.

    assign scan_status = {o_slot.valid, 2'b00, o_slot.index};

    // One read at a time; data returned one cycle after the address.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= asp_pkg::RESP_OKAY;
        end
        else if (o_arready && i_arvalid)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= asp_pkg::RESP_OKAY;
            // Narrow registers sit in the low bits; upper bits read zero.
            case (i_araddr)
                asp_pkg::SCAN_SELECT_HIGH_OFS: o_rdata <= {16'h0000, scan_select_high_reg};
                asp_pkg::SCAN_SELECT_LOW_OFS: o_rdata <= {16'h0000, scan_select_low_reg};
                asp_pkg::PIN_ANALOG_CONFIG_HIGH_OFS:
                    o_rdata <= {16'h0000, pin_analog_config_high_reg};
                asp_pkg::PIN_ANALOG_CONFIG_LOW_OFS:
                    o_rdata <= {16'h0000, pin_analog_config_low_reg};
                asp_pkg::SECOND_PIN_CONFIG_LOW_OFS:
                    o_rdata <= {16'h0000, second_pin_config_low_reg};
                asp_pkg::CONTROL_OFS: o_rdata <= {29'h0000_0000, control_reg};
                asp_pkg::SCAN_STATUS_OFS: o_rdata <= {22'h00_0000, o_slot.valid,
                                                      o_slot.source == asp_pkg::ASP_SRC_PIN,
                                                      scan_status};
                default:
                begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= asp_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (o_rvalid)
        begin
            if (i_rready)
            begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
        else
        begin
            o_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin mode
    // ----------------------------------------------------------------
    // Bits of missing inputs are stored but have no effect on any pin.
    always_comb
    begin
        for (int n = 0; n < 32; n++)
        begin
            present[n] = (6'(n) < asp_pkg::INPUTS_PRESENT);
        end
    end

    logic [31:0] digital_next; // Requested digital state per input.

    // Both low registers can request digital mode on inputs 0 to 15;
    // either module disable forces every shared pin digital.
    always_comb
    begin
        digital_next = {pin_analog_config_high_reg,
                        pin_analog_config_low_reg | second_pin_config_low_reg};
        if (control_reg[asp_pkg::CTRL_DISABLE_BIT])
        begin
            digital_next = 32'hffff_ffff;
        end
        else if (control_reg[asp_pkg::CTRL_SECOND_DISABLE_BIT])
        begin
            digital_next[15:0] = 16'hffff;
        end
        digital_next = digital_next & present;
    end

    // Digital: read path on, mux grounded. Analog: read off, pin sampled.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pin_digital <= 32'h0000_0000;
            o_port_read_en <= 32'h0000_0000;
            o_mux_to_ground <= 32'h0000_0000;
        end
        else
        begin
            o_pin_digital <= digital_next;
            o_port_read_en <= digital_next;
            o_mux_to_ground <= digital_next;
        end
    end

    // ----------------------------------------------------------------
    // Scan sequencer
    // ----------------------------------------------------------------
    logic [7:0] step_cnt_reg; // Divider for the step enable.
    logic step_en; // One-cycle step pulse.
    logic pick_found;
    logic [4:0] pick_next;

    assign scan_mask = {scan_select_high_reg, scan_select_low_reg};

    // Steps are paced slowly so a converter has time per slot.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            step_cnt_reg <= 8'h00;
        end
        else if (step_cnt_reg == asp_pkg::SCAN_STEP_CYCLES - 8'h01)
        begin
            step_cnt_reg <= 8'h00;
        end
        else
        begin
            step_cnt_reg <= step_cnt_reg + 8'h01;
        end
    end

    assign step_en = (step_cnt_reg == asp_pkg::SCAN_STEP_CYCLES - 8'h01);

    asp_scan_pick u_pick
    (
        .i_mask(scan_mask),
        .i_cur(o_slot.valid ? o_slot.index : 5'h1f),
        .o_found(pick_found),
        .o_next(pick_next)
    );

    // Ascending walk through selected inputs, wrapping to the lowest.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_slot <= '{valid: 1'b0, index: 5'h00, source: asp_pkg::ASP_SRC_PIN};
        end
        else if (!control_reg[asp_pkg::CTRL_SCAN_RUN_BIT] || !pick_found)
        begin
            o_slot.valid <= 1'b0;
        end
        else if (step_en)
        begin
            o_slot.valid <= 1'b1;
            o_slot.index <= pick_next;
            if (6'(pick_next) >= asp_pkg::INPUTS_PRESENT)
            begin
                // Missing inputs convert a reference instead of a pin.
                o_slot.source <= pick_next[4] ? asp_pkg::ASP_SRC_LOW_REFERENCE_LEVEL
                                              : asp_pkg::ASP_SRC_NEGREF;
            end
            else
            begin
                o_slot.source <= asp_pkg::ASP_SRC_PIN;
            end
        end
    end

endmodule // asp_scan_cfg

//--- tb/asp_scan_cfg_asserts.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the scan and pin configuration block
// ----------------------------------------------------------------
module asp_scan_cfg_asserts
(
    // Clock and reset.
    input logic i_ref_clk,
    input logic i_rstn,
    // Register bus handshakes.
    input logic i_awvalid,
    input logic o_awready,
    input logic i_wvalid,
    input logic o_wready,
    input logic o_bvalid,
    input logic i_bready,
    input logic [1:0] o_bresp,
    input logic i_arvalid,
    input logic o_arready,
    input logic o_rvalid,
    input logic i_rready,
    input logic [31:0] o_rdata,
    input logic [1:0] o_rresp,
    // Pin modes and scan slot.
    input logic [31:0] o_pin_digital,
    input logic [31:0] o_port_read_en,
    input logic [31:0] o_mux_to_ground,
    input asp_pkg::asp_slot_t o_slot
);

    // One clock domain, so one clocking and one disable serve all.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    // The three pin views must never disagree, or a pin half-switches.
    chk_pin_same: assert property (
        o_port_read_en == o_pin_digital && o_mux_to_ground == o_pin_digital)
        else $error("pin mode outputs disagree");
    // Every input exists here, so a slot always samples its pin.
    chk_slot_source: assert property (
        o_slot.valid |-> o_slot.source == asp_pkg::ASP_SRC_PIN)
        else $error("scan slot source wrong");
    // A new slot stays put for a while since steps are spaced out.
    chk_scan_hold: assert property (
        o_slot.valid && $changed(o_slot.index) |=>
        (!o_slot.valid || $stable(o_slot.index)) [*8])
        else $error("scan slot moved too soon");
    // Both halves are held one edge, the write lands the next, then bvalid shows.
    chk_wr_answer: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid |=>
        !o_bvalid ##1 o_bvalid)
        else $error("write not answered in two cycles");
    chk_rd_answer: assert property (
        i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read not answered next cycle");
    chk_b_stands: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    chk_r_stands: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read response dropped");
    // A taken address closes its slot until the held write is used.
    chk_b_refuse: assert property (
        i_awvalid && o_awready |=> !o_awready)
        else $error("write address taken twice");
    chk_b_release: assert property (
        o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
        else $error("write channel not reopened");
    // Registers are at most 16 bits wide, so the upper half reads as zero.
    chk_r_upper: assert property (
        o_rvalid |-> o_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");

endmodule // asp_scan_cfg_asserts

bind asp_scan_cfg asp_scan_cfg_asserts i_asp_scan_cfg_asserts
(
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_pin_digital(o_pin_digital), .o_port_read_en(o_port_read_en),
    .o_mux_to_ground(o_mux_to_ground), .o_slot(o_slot)
);

//--- tb/asp_scan_cfg_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Self-checking bench for the scan and pin configuration block
// ----------------------------------------------------------------
module asp_scan_cfg_tb;

    // Clock, reset and bus stimulus.
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_awaddr = 8'h00;
    logic [7:0] i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    // Block outputs.
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata, o_pin_digital, o_port_read_en, o_mux_to_ground;
    asp_pkg::asp_slot_t o_slot;
    // Scoreboard notes: read notes hold mask, response and data.
    int err_total = 0;
    int checked = 0;
    logic [31:0] lfsr = 32'h0001_1f47;
    logic [1:0] exp_b[$];
    logic [65:0] exp_r[$];
    logic [4:0] exp_s[$];
    logic [4:0] prev_idx = 5'h1f;
    logic [15:0] h, l1, l2;
    logic [31:0] pins;

    asp_scan_cfg i_asp_scan_cfg
    (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_pin_digital(o_pin_digital),
        .o_port_read_en(o_port_read_en), .o_mux_to_ground(o_mux_to_ground),
        .o_slot(o_slot)
    );

    // Free-running 10 MHz clock.
    initial
    begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Galois-free shift register; cheap and repeatable from its seed.
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic fail(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
            fail(m);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One write; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge i_ref_clk);
        exp_b.push_back(r);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
            n++;
        end
        while (!o_bvalid && n < 60);
        i_bready <= 1'b0;
        if (n >= 60)
        begin
            fail("write hang");
            wrap_up();
        end
    endtask

    // One read; the monitor judges the data against the note.
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] r,
                      input logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        exp_r.push_back({m, r, d});
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            if (o_arready)
                i_arvalid <= 1'b0;
            n++;
        end
        while (!o_rvalid && n < 60);
        i_rready <= 1'b0;
        if (n >= 60)
        begin
            fail("read hang");
            wrap_up();
        end
    endtask

    // ----------------------------------------------------------------
    // Monitor
    // ----------------------------------------------------------------
    // Takes the oldest note off a queue whenever the block answers.
    always @(posedge i_ref_clk)
    begin
        logic [65:0] e;
        if (o_bvalid && i_bready)
        begin
            checked++;
            if (exp_b.size() == 0 || o_bresp !== exp_b.pop_front())
                fail("write response");
        end
        if (o_rvalid && i_rready)
        begin
            checked++;
            e = (exp_r.size() == 0) ? '1 : exp_r.pop_front();
            if (((o_rdata ^ e[31:0]) & e[65:34]) !== 32'h0 || o_rresp !== e[33:32])
                fail("read data");
        end
        // A scan step shows as a new index on a valid slot.
        if (o_slot.valid === 1'b1 && o_slot.index !== prev_idx)
        begin
            prev_idx = o_slot.index;
            if (exp_s.size() != 0)
            begin
                checked++;
                if (o_slot.index !== exp_s.pop_front() || o_slot.source !== asp_pkg::ASP_SRC_PIN)
                    fail("scan slot");
            end
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int n;
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        // Everything clears at reset, so every pin starts analog.
        chk(o_pin_digital, 32'h0, "pins at reset");
        for (int a = 0; a < 6; a++)
            rd(8'(a * 4), '1, asp_pkg::RESP_OKAY, 32'h0);
        $display("test reset done");
        // Every bit of the five 16-bit registers is writable, whatever inputs exist.
        for (int k = 0; k < 5; k++)
        begin
            lfsr = rnd(lfsr);
            wr(8'(k * 4), lfsr, asp_pkg::RESP_OKAY);
            rd(8'(k * 4), '1, asp_pkg::RESP_OKAY, {16'h0, lfsr[15:0]});
        end
        $display("test registers done");
        // Random pin configs under each disable combination.
        for (int k = 0; k < 4; k++)
        begin
            lfsr = rnd(lfsr);
            h = lfsr[15:0];
            l1 = lfsr[31:16];
            lfsr = rnd(lfsr);
            l2 = lfsr[15:0];
            wr(asp_pkg::PIN_ANALOG_CONFIG_HIGH_OFS, {16'h0, h}, asp_pkg::RESP_OKAY);
            wr(asp_pkg::PIN_ANALOG_CONFIG_LOW_OFS, {16'h0, l1}, asp_pkg::RESP_OKAY);
            wr(asp_pkg::SECOND_PIN_CONFIG_LOW_OFS, {16'h0, l2}, asp_pkg::RESP_OKAY);
            wr(asp_pkg::CONTROL_OFS, {30'h0, k[1:0]}, asp_pkg::RESP_OKAY);
            pins = k[0] ? '1 : {h, l1 | l2 | {16{k[1]}}};
            repeat (2) @(negedge i_ref_clk);
            chk(o_pin_digital, pins, "pin digital");
            chk(o_port_read_en, pins, "port read");
            chk(o_mux_to_ground, pins, "mux ground");
        end
        $display("test pins done");
        // Unmapped and read-only places are refused without effect.
        wr(8'h1c, lfsr, asp_pkg::RESP_SLVERR);
        wr(asp_pkg::SCAN_STATUS_OFS, lfsr, asp_pkg::RESP_SLVERR);
        rd(8'h1c, 32'h0, asp_pkg::RESP_SLVERR, 32'h0);
        rd(asp_pkg::PIN_ANALOG_CONFIG_HIGH_OFS, '1, asp_pkg::RESP_OKAY, {16'h0, h});
        $display("test refusals done");
        // Scan over inputs 2, 5, 16 and 31, wrapping once.
        wr(asp_pkg::SCAN_SELECT_HIGH_OFS, 32'h0000_8001, asp_pkg::RESP_OKAY);
        wr(asp_pkg::SCAN_SELECT_LOW_OFS, 32'h0000_0024, asp_pkg::RESP_OKAY);
        exp_s = '{5'h02, 5'h05, 5'h10, 5'h1f, 5'h02, 5'h05};
        wr(asp_pkg::CONTROL_OFS, 32'h0000_0004, asp_pkg::RESP_OKAY);
        for (n = 0; n < 300 && exp_s.size() != 0; n++)
            @(posedge i_ref_clk);
        if (exp_s.size() != 0)
        begin
            fail("scan stalled");
            wrap_up();
        end
        wr(asp_pkg::CONTROL_OFS, 32'h0, asp_pkg::RESP_OKAY);
        $display("test scan done");
        // A second reset after the scan is stopped clears pins and slot again.
        i_rstn <= 1'b0;
        repeat (3) @(negedge i_ref_clk);
        chk(o_pin_digital, 32'h0, "pins in reset");
        chk({31'h0, o_slot.valid}, 32'h0, "slot in reset");
        @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        rd(asp_pkg::SCAN_SELECT_HIGH_OFS, '1, asp_pkg::RESP_OKAY, 32'h0);
        repeat (4) @(posedge i_ref_clk);
        $display("test second reset done");
        wrap_up();
    end

endmodule // asp_scan_cfg_tb
